// ---- src/gtm_mux.sv ----
// pin mux for gpio test access, special roles and scan mode
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module gtm_mux (
  input wire logic clock,
  input wire logic reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic scan_request,
  input wire logic clk_sys_out,
  input wire logic sda_drive_low,
  input wire logic dbg_data_out,
  input wire logic dbg_data_oe,
  input wire logic led_on,
  input wire logic [1:0] scan_out_data,
  input wire logic [9:0] pad_in,
  output logic [9:0] pad_out,
  output logic [9:0] pad_oe_n,
  output logic [9:0] pin_in,
  output logic [9:0] pullup_en,
  output logic [9:0] atb_sense0_sel,
  output logic [9:0] atb_sense1_sel,
  output logic [9:0] atb_force_sel,
  output logic [9:0] accurate_sel,
  output logic gpio_interval,
  output logic debug_data_pin,
  output logic debug_clock_pin,
  output logic led_drive,
  output logic [1:0] scan_in_data,
  output logic scan_enable,
  output logic scan_clock,
  output logic scan_mode
);
  import gtm_pkg::*;

  // ****************************************************
  // registers
  // ****************************************************
  logic [3:0] ind_reg;
  logic [2:0] fs_reg;
  logic [7:0] role_reg;
  logic scan_reg;
  logic [9:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;
  logic test_write, role_write;

  // ****************************************************
  // register write decode
  // ****************************************************
  // one place decides which register a strobe hits
  function automatic logic gtm_hit(input logic strobe, input logic [1:0] addr,
                                   input logic [1:0] target);
    return strobe && addr == target;
  endfunction : gtm_hit

  assign test_write = gtm_hit(reg_write, reg_addr, GTM_ADDR_TEST);
  assign role_write = gtm_hit(reg_write, reg_addr, GTM_ADDR_ROLE);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ind_reg <= GTM_IND_RESET;
      fs_reg <= GTM_FS_RESET;
      role_reg <= GTM_ROLE_RESET;
    end else if (test_write) begin
      ind_reg <= reg_wdata[GTM_TEST_IND_LSB +: 4];
      fs_reg <= reg_wdata[GTM_TEST_FS_LSB +: 3];
    end else if (role_write) begin
      role_reg <= reg_wdata;
    end
  end

  // ****************************************************
  // scan mode latch
  // ****************************************************
  // sticky: nothing but power-on reset clears it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scan_reg <= 1'b0;
    end else if (scan_request || (role_write && reg_wdata[GTM_ROLE_SCAN])) begin
      scan_reg <= 1'b1;
    end
  end
  assign scan_mode = scan_reg;

  // ****************************************************
  // register read back
  // ****************************************************
  // idle cycles and unmapped offsets read as zero

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        GTM_ADDR_TEST: reg_rdata <= {1'b0, fs_reg, ind_reg};
        // bit 7 shows the scan latch, not the written bit
        GTM_ADDR_ROLE: reg_rdata <= {scan_reg, role_reg[6:0]};
        GTM_ADDR_STAT: reg_rdata <= {7'h00, scan_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************************
  // pad input synchroniser, three stages
  // ****************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_reg <= 10'h000;
      sync2_reg <= 10'h000;
      sync3_reg <= 10'h000;
      pin_reg <= 10'h000;
    end else begin
      // three flops keep metastable levels off pin_reg
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // change accepted only when stages two and three agree
      pin_reg <= (sync2_reg == sync3_reg) ? sync3_reg : pin_reg;
    end
  end

  // ****************************************************
  // test bus decode
  // ****************************************************
  function automatic logic [9:0] gtm_onehot(input logic [3:0] idx);
    logic [9:0] v;
    v = 10'h000;
    // index 10 to 15 selects nothing
    if (idx < 4'hA) begin
      v[idx] = 1'b1;
    end
    return v;
  endfunction : gtm_onehot

  // ****************************************************
  // mode decode
  // ****************************************************
  // one-hot mode so every case arm is a single bit
  gtm_fs_e fs_mode;
  always_comb begin
    case (fs_reg)
      3'h0: fs_mode = GTM_FS_NONE;
      3'h1: fs_mode = GTM_FS_SENSE;
      3'h2: fs_mode = GTM_FS_FORCE;
      3'h3: fs_mode = GTM_FS_FORCE_SENSE;
      3'h4: fs_mode = GTM_FS_ACCURATE;
      3'h5: fs_mode = GTM_FS_DIFF;
      3'h6: fs_mode = GTM_FS_FORCE_PU;
      default: fs_mode = GTM_FS_FORCE_SENSE_PU;
    endcase
  end

  logic [9:0] sel, sel_up;
  // next pin up; pin 9 has no neighbour
  assign sel = scan_reg ? 10'h000 : gtm_onehot(ind_reg);
  assign sel_up = {sel[8:0], 1'b0};

  logic [9:0] s0, s1, fc, acc, pu_off;
  always_comb begin
    s0 = 10'h000;
    s1 = 10'h000;
    fc = 10'h000;
    acc = 10'h000;
    pu_off = 10'h000;
    case (fs_mode)
      GTM_FS_NONE: begin
        s0 = 10'h000;
      end
      GTM_FS_SENSE: begin
        s0 = sel;
        pu_off = sel;
      end
      GTM_FS_FORCE: begin
        fc = sel;
        pu_off = sel;
      end
      GTM_FS_FORCE_SENSE: begin
        fc = sel;
        s0 = sel;
        pu_off = sel;
      end
      GTM_FS_ACCURATE: begin
        acc = sel;
      end
      GTM_FS_DIFF: begin
        s0 = sel;
        s1 = sel_up;
        pu_off = sel | sel_up;
      end
      GTM_FS_FORCE_PU: begin
        fc = sel;
      end
      GTM_FS_FORCE_SENSE_PU: begin
        fc = sel;
        s0 = sel;
      end
      default: begin
        s0 = 10'h000;
      end
    endcase
  end

  // ****************************************************
  // test bus outputs
  // ****************************************************
  // registered so the analog switches never see decode glitches
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      atb_sense0_sel <= 10'h000;
      atb_sense1_sel <= 10'h000;
      atb_force_sel <= 10'h000;
      accurate_sel <= 10'h000;
      pullup_en <= 10'h3FF;
      gpio_interval <= 1'b0;
    end else begin
      atb_sense0_sel <= s0;
      atb_sense1_sel <= s1;
      atb_force_sel <= fc;
      accurate_sel <= acc;
      pullup_en <= ~pu_off;
      // pin 0 has no slicer, so it never feeds the interval
      gpio_interval <= |(acc[9:1] & pin_reg[9:1]);
    end
  end

  // accurate entry masks pin 0 combinationally, no sync delay
  assign pin_in = {pin_reg[9:1], pin_reg[0] & ~acc[0]};

  // ****************************************************
  // special roles and scan
  // ****************************************************
  // led and debug pins follow the scan latch one cycle later, through the output registers
  logic special_on;
  assign special_on = ~scan_reg;
  logic dbg_on;
  assign dbg_on = special_on & role_reg[GTM_ROLE_DBG];

  logic [9:0] out_next, oe_n_next;
  always_comb begin
    out_next = 10'h000;
    oe_n_next = 10'h3FF;
    if (scan_reg) begin
      // scan wins over every other role
      // outputs push-pull, inputs left undriven
      out_next[GTM_SCAN_OUT0_PIN] = scan_out_data[0];
      out_next[GTM_SCAN_OUT1_PIN] = scan_out_data[1];
      oe_n_next[GTM_SCAN_OUT0_PIN] = 1'b0;
      oe_n_next[GTM_SCAN_OUT1_PIN] = 1'b0;
    end else begin
      if (role_reg[GTM_ROLE_CLK4]) begin
        out_next[GTM_CLKOUT_PIN_A] = clk_sys_out;
        oe_n_next[GTM_CLKOUT_PIN_A] = 1'b0;
      end
      if (role_reg[GTM_ROLE_CLK6]) begin
        out_next[GTM_CLKOUT_PIN_B] = clk_sys_out;
        oe_n_next[GTM_CLKOUT_PIN_B] = 1'b0;
      end
      if (role_reg[GTM_ROLE_SDA]) begin
        // open collector: drive only while pulling low
        out_next[GTM_SDA_PIN] = 1'b0;
        oe_n_next[GTM_SDA_PIN] = ~sda_drive_low;
      end
      if (role_reg[GTM_ROLE_DBG]) begin
        // host holds data low when idle; we only drive on request
        out_next[GTM_DBG_DATA_PIN] = dbg_data_out;
        oe_n_next[GTM_DBG_DATA_PIN] = ~dbg_data_oe;
      end
    end
  end

  // ****************************************************
  // output registers
  // ****************************************************
  // pads released and pullups on out of reset
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pad_out <= 10'h000;
      pad_oe_n <= 10'h3FF;
      led_drive <= 1'b0;
      debug_data_pin <= 1'b0;
      debug_clock_pin <= 1'b0;
      scan_in_data <= 2'h0;
      scan_enable <= 1'b0;
      scan_clock <= 1'b0;
    end else begin
      pad_out <= out_next;
      pad_oe_n <= oe_n_next;
      led_drive <= special_on & role_reg[GTM_ROLE_LED] & led_on;
      debug_data_pin <= dbg_on & pin_reg[GTM_DBG_DATA_PIN];
      debug_clock_pin <= dbg_on & pin_reg[GTM_DBG_CLOCK_PIN];
      scan_in_data <= scan_reg ? {pin_reg[GTM_SCAN_IN1_PIN], pin_reg[GTM_SCAN_IN0_PIN]}
                               : 2'h0;
      scan_enable <= scan_reg & pin_reg[GTM_SCAN_EN_PIN];
      scan_clock <= scan_reg & pin_reg[GTM_SCAN_CLK_PIN];
    end
  end
endmodule : gtm_mux
`default_nettype wire

// ---- include/gtm_pkg.sv ----
// constants and types for the gpio test mux and scan setup block
package gtm_pkg;
  localparam int GTM_PINS = 10;
  localparam logic [3:0] GTM_IND_RESET = 4'hF;
  localparam logic [2:0] GTM_FS_RESET = 3'h0;
  localparam logic [3:0] GTM_CLKOUT_PIN_A = 4'h4;
  localparam logic [3:0] GTM_CLKOUT_PIN_B = 4'h6;
  localparam int GTM_SDA_PIN = 1;
  localparam int GTM_DBG_DATA_PIN = 4;
  localparam int GTM_DBG_CLOCK_PIN = 5;
  localparam int GTM_LED_PIN = 5;
  localparam int GTM_SCAN_IN0_PIN = 0;
  localparam int GTM_SCAN_IN1_PIN = 1;
  localparam int GTM_SCAN_OUT0_PIN = 2;
  localparam int GTM_SCAN_OUT1_PIN = 3;
  localparam int GTM_SCAN_EN_PIN = 4;
  localparam int GTM_SCAN_CLK_PIN = 5;
  // register offsets
  localparam logic [1:0] GTM_ADDR_TEST = 2'h0;
  localparam logic [1:0] GTM_ADDR_ROLE = 2'h1;
  localparam logic [1:0] GTM_ADDR_STAT = 2'h2;
  // test register fields
  localparam int GTM_TEST_IND_LSB = 0;
  localparam int GTM_TEST_FS_LSB = 4;
  // role register fields
  localparam int GTM_ROLE_CLK4 = 0;
  localparam int GTM_ROLE_CLK6 = 1;
  localparam int GTM_ROLE_SDA = 2;
  localparam int GTM_ROLE_DBG = 3;
  localparam int GTM_ROLE_LED = 4;
  localparam int GTM_ROLE_SCAN = 7;
  localparam logic [7:0] GTM_ROLE_RESET = 8'h00;
  typedef enum logic [7:0] {
    GTM_FS_NONE = 8'h01,
    GTM_FS_SENSE = 8'h02,
    GTM_FS_FORCE = 8'h04,
    GTM_FS_FORCE_SENSE = 8'h08,
    GTM_FS_ACCURATE = 8'h10,
    GTM_FS_DIFF = 8'h20,
    GTM_FS_FORCE_PU = 8'h40,
    GTM_FS_FORCE_SENSE_PU = 8'h80
  } gtm_fs_e;
endpackage : gtm_pkg

// ---- testbench/gtm_mux_checker.sv ----
// assertions on the gpio test mux ports
`timescale 1ns/1ns
`default_nettype none
module gtm_mux_checker (
  input wire logic clock,
  input wire logic reset,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [9:0] pin_in,
  input wire logic [9:0] pad_out,
  input wire logic [9:0] pad_oe_n,
  input wire logic [9:0] atb_sense0_sel,
  input wire logic [9:0] atb_force_sel,
  input wire logic [9:0] accurate_sel,
  input wire logic led_drive,
  input wire logic scan_mode
);
  logic tw;
  logic [9:0] sel;
  assign tw = reg_write && reg_addr == 2'h0;
  assign sel = atb_sense0_sel | atb_force_sel | accurate_sel;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ****
  // properties
  // ****
  property p_idx;
    tw && reg_wdata[3:0] > 4'h9 |-> ##2 sel == 10'h000;
  endproperty
  a_idx: assert property (p_idx) else $error("pin chosen by bad index");
  property p_none;
    tw && reg_wdata[6:4] == 3'h0 |-> ##2 (atb_sense0_sel | atb_force_sel) == 10'h000;
  endproperty
  a_none: assert property (p_none) else $error("bus link in mode 0");
  property p_sense;
    tw && reg_wdata[6:4] == 3'h1 && reg_wdata[3:0] < 4'hA
      |-> ##2 (scan_mode || (atb_sense0_sel == (10'h001 << $past(reg_wdata[3:0], 2))));
  endproperty
  a_sense: assert property (p_sense) else $error("sense select wrong");
  property p_scan;
    scan_mode && $past(scan_mode) |-> sel == 10'h000;
  endproperty
  a_scan: assert property (p_scan) else $error("select live in scan");
  property p_stick;
    scan_mode |=> scan_mode;
  endproperty
  a_stick: assert property (p_stick) else $error("scan mode left");
  property p_led;
    $past(scan_mode) |-> !led_drive;
  endproperty
  a_led: assert property (p_led) else $error("led on in scan");
  property p_acc0;
    accurate_sel[0] |-> !$past(pin_in[0]);
  endproperty
  a_acc0: assert property (p_acc0) else $error("pin 0 not masked");
  property p_sda;
    !pad_oe_n[1] |-> !pad_out[1];
  endproperty
  a_sda: assert property (p_sda) else $error("pin 1 driven high");
  property p_pins;
    scan_mode && $past(scan_mode) |-> pad_oe_n[5:0] == 6'h33;
  endproperty
  a_pins: assert property (p_pins) else $error("scan pin drive wrong");
  c_diff: cover property (tw && reg_wdata[6:4] == 3'h5);
  c_scan: cover property ($rose(scan_mode));
  c_acc: cover property (accurate_sel[0]);
endmodule : gtm_mux_checker
`default_nettype wire

// ---- testbench/gtm_far.sv ----
// pad and scan chain model on the far side
`timescale 1ns/1ns
`default_nettype none
module gtm_far (
  input wire logic clock,
  input wire logic [9:0] pad_out,
  input wire logic [9:0] pad_oe_n,
  input wire logic [9:0] pullup_en,
  input wire logic [9:0] ext_en,
  input wire logic [9:0] ext_val,
  output logic [9:0] pad_in,
  output logic [1:0] scan_out_data
);
  logic tog = 1'b0;
  // unpulled released lines wander, never hold a value
  always @(posedge clock) tog <= ~tog;
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pullup_en[i] | tog;
    end
  end
  // scan outputs driven push-pull every cycle
  assign scan_out_data = {tog, ~tog};
endmodule : gtm_far
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the gpio test mux
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import gtm_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic scan_request = 1'b0;
  logic clk_sys_out = 1'b1;
  logic sda_drive_low = 1'b1;
  logic dbg_data_out = 1'b0;
  logic dbg_data_oe = 1'b0;
  logic led_on = 1'b1;
  logic [9:0] xv = 10'h009; // debug data idles low
  logic [7:0] reg_rdata;
  logic [1:0] scan_out_data, scan_in_data;
  logic [9:0] pad_in, pad_out, pad_oe_n, pin_in, pullup_en, h;
  logic [9:0] atb_sense0_sel, atb_sense1_sel, atb_force_sel, accurate_sel;
  logic gpio_interval, debug_data_pin, debug_clock_pin, led_drive;
  logic scan_enable, scan_clock, scan_mode;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  // index, mode, then sense0 sense1 force accurate pullup
  logic [11:0] rows [11] = '{{4'h3, 3'h0, 5'h01}, {4'h3, 3'h1, 5'h10},
    {4'h3, 3'h2, 5'h04}, {4'h3, 3'h3, 5'h14}, {4'h3, 3'h4, 5'h03},
    {4'h3, 3'h5, 5'h18}, {4'h3, 3'h6, 5'h05}, {4'h3, 3'h7, 5'h15},
    {4'h9, 3'h5, 5'h18}, {4'hA, 3'h1, 5'h10}, {4'h0, 3'h4, 5'h03}};
  gtm_mux dut_u (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .scan_request, .clk_sys_out, .sda_drive_low, .dbg_data_out,
    .dbg_data_oe, .led_on, .scan_out_data, .pad_in, .pad_out, .pad_oe_n, .pin_in,
    .pullup_en, .atb_sense0_sel, .atb_sense1_sel, .atb_force_sel, .accurate_sel,
    .gpio_interval, .debug_data_pin, .debug_clock_pin, .led_drive, .scan_in_data,
    .scan_enable, .scan_clock, .scan_mode);
  gtm_far far_u (.clock, .pad_out, .pad_oe_n, .pullup_en, .ext_en(10'h01B),
    .ext_val(xv), .pad_in, .scan_out_data);
  always #5 clock = ~clock;
  task automatic print_verdict;
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clock) begin
    cyc++;
    if (cyc > 1000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic cmp(input logic [9:0] g, input logic [9:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic cb(input logic g, input logic e);
    cmp({9'h000, g}, {9'h000, e});
  endtask : cb
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    cmp({2'h0, reg_rdata}, {2'h0, e});
  endtask : rreg
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rreg(GTM_ADDR_TEST, 8'h0F);
    foreach (rows[i]) begin
      wreg(GTM_ADDR_TEST, {1'b0, rows[i][7:5], rows[i][11:8]});
      repeat (2) @(negedge clock);
      h = 10'h001 << rows[i][11:8];
      cmp(atb_sense0_sel, {10{rows[i][4]}} & h);
      cmp(atb_sense1_sel, {10{rows[i][3]}} & (h << 1));
      cmp(atb_force_sel, {10{rows[i][2]}} & h);
      cmp(accurate_sel, {10{rows[i][1]}} & h);
      cmp(pullup_en, rows[i][0] ? 10'h3FF : ~(h | (h << rows[i][3])));
    end
    repeat (6) @(negedge clock);
    cb(pin_in[0], 1'b0);
    wreg(GTM_ADDR_TEST, 8'h43);
    repeat (6) @(negedge clock);
    cb(gpio_interval, 1'b1);
    cb(pin_in[0], 1'b1);
    for (int k = 1; k < 4; k++) begin
      wreg(GTM_ADDR_ROLE, 8'(k));
      repeat (2) @(negedge clock);
      cmp({8'h00, pad_oe_n[6], pad_oe_n[4]}, 10'(~k & 3));
      cmp({8'h00, pad_out[6], pad_out[4]} & 10'(k), 10'(k));
    end
    wreg(GTM_ADDR_ROLE, 8'h04);
    repeat (2) @(negedge clock);
    cmp({8'h00, pad_oe_n[1], pad_out[1]}, 10'h000);
    @(posedge clock);
    sda_drive_low <= 1'b0;
    repeat (2) @(negedge clock);
    cb(pad_oe_n[1], 1'b1);
    wreg(GTM_ADDR_ROLE, 8'h08);
    @(posedge clock);
    xv[4] <= 1'b1; // start bit opens a transfer
    repeat (6) @(negedge clock);
    cb(debug_data_pin, 1'b1);
    cb(debug_clock_pin, 1'b1);
    @(posedge clock);
    dbg_data_oe <= 1'b1;
    repeat (2) @(negedge clock);
    cmp({8'h00, pad_oe_n[4], pad_out[4]}, 10'h000);
    @(posedge clock);
    dbg_data_oe <= 1'b0;
    wreg(GTM_ADDR_TEST, 8'h12); // pullup off ahead of scan
    wreg(GTM_ADDR_ROLE, 8'h10);
    repeat (2) @(negedge clock);
    cb(led_drive, 1'b1);
    @(posedge clock);
    scan_request <= 1'b1;
    @(posedge clock);
    scan_request <= 1'b0;
    repeat (2) @(negedge clock);
    cb(led_drive, 1'b0);
    cmp(atb_sense0_sel, 10'h000);
    wreg(GTM_ADDR_ROLE, 8'h18);
    rreg(GTM_ADDR_STAT, 8'h01);
    rreg(2'h3, 8'h00);
    repeat (6) @(negedge clock);
    cmp({8'h00, scan_in_data}, {8'h00, xv[1:0]});
    cb(pad_out[3] ^ pad_out[2], 1'b1);
    cb(scan_enable, xv[4]);
    cb(scan_clock, 1'b1);
    cb(debug_data_pin, 1'b0);
    cb(led_drive, 1'b0);
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    cb(scan_mode, 1'b0);
    cmp(pullup_en, 10'h3FF);
    print_verdict();
  end
endmodule : testbench
bind gtm_mux gtm_mux_checker chk_u (.clock, .reset, .reg_addr, .reg_wdata, .reg_write,
  .pin_in, .pad_out, .pad_oe_n, .atb_sense0_sel, .atb_force_sel, .accurate_sel,
  .led_drive, .scan_mode);
`default_nettype wire
